/* File: rtl/fcb_bank.sv */
// Channel B upper-tap coefficient bank with AHB-Lite slave and filter
//
// Contract
// (RULE_01) Each coefficient sits in bits 11:0 and is signed two's complement.
// (RULE_02) Index 0x453 holds the tap six coefficient in dual-channel mode.
// (RULE_03) Index 0x455 holds the tap seven coefficient in dual-channel mode.
// (RULE_04) Index 0x457 holds the tap eight coefficient in dual-channel mode.
// (RULE_05) Index 0x459 holds the ninth and last tap coefficient.
// (RULE_06) Reads return bit 11 as zero and the rest as written.
// (RULE_07) Every register resets to zero, reserved bits included.
// (RULE_08) Bits 15:12 are read-write storage that the filter ignores.
// (RULE_09) Nine taps; the fifth is 18 bits wide and the others 12 bits.
// (RULE_10) The output sums nine newest samples by tap, tap one on the newest.
// (RULE_11) A written coefficient applies to later samples without a load.
//
// The AHB-Lite slave port was left to the implementer.
module fcb_bank
    import fcb_pkg::*;
#(
    parameter int SAMP_W = 12,
    parameter int ACC_W = 34
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [fcb_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [fcb_pkg::BUS_W-1:0] hwdata,
    input wire logic hready,
    output logic [fcb_pkg::BUS_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Converter mode
    input wire logic dualChanMode,
    // Coefficients of taps one to five from the neighbouring banks
    input wire logic [fcb_pkg::COEF_W-1:0] tap1Coef,
    input wire logic [fcb_pkg::COEF_W-1:0] tap2Coef,
    input wire logic [fcb_pkg::COEF_W-1:0] tap3Coef,
    input wire logic [fcb_pkg::COEF_W-1:0] tap4Coef,
    input wire logic [fcb_pkg::CTR_W-1:0] centerTapCoef,
    // Channel B samples
    input wire logic sampleValid,
    input wire logic [SAMP_W-1:0] sampleIn,
    // Coefficient fields towards the datapath
    output logic [fcb_pkg::COEF_W-1:0] tap6Coef,
    output logic [fcb_pkg::COEF_W-1:0] tap7Coef,
    output logic [fcb_pkg::COEF_W-1:0] tap8Coef,
    output logic [fcb_pkg::COEF_W-1:0] tap9Coef,
    // Filter result
    output logic [ACC_W-1:0] filtOut,
    output logic filtValid
);
    import fcb_pkg::*;

    // Register storage
    logic [REG_W-1:0] coefQ [NUM_BANK];
    logic [REG_W-1:0] coefNext [NUM_BANK];
    logic [NUM_BANK-1:0] wrEn;
    logic [NUM_BANK-1:0] addrHit;

    // Bus phase state
    logic wrPend_reg;
    logic wrPend_next;
    logic [NUM_BANK-1:0] wrSel_reg;
    logic [NUM_BANK-1:0] wrSel_next;
    logic [BUS_W-1:0] rdata_reg;
    logic [BUS_W-1:0] rdata_next;
    logic ready_reg;
    logic ready_next;
    logic resp_reg;
    logic resp_next;

    // Address phase qualification
    logic addrPhase;
    logic idxAligned;
    logic [IDX_W-1:0] reqIdx;
    logic upperZero;

    // Filter coefficient vector
    logic [NUM_TAPS-1:0][CTR_W-1:0] filtCoefs;

    assign addrPhase = hsel && hready &&
                       (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign reqIdx = haddr[IDX_LSB +: IDX_W];
    assign idxAligned = (haddr[IDX_LSB-1:0] == 2'b00);
    assign upperZero = (haddr[ADDR_W-1:IDX_LSB+IDX_W] == '0);

    genvar b;
    generate
        for (b = 0; b < NUM_BANK; b++) begin : g_bank
            // RULE_02 RULE_03 RULE_04 RULE_05 below via BANK_IDX
            assign addrHit[b] = idxAligned && upperZero &&
                                (reqIdx == BANK_IDX[b]); // RULE_02
            assign wrEn[b] = wrPend_reg && wrSel_reg[b];
            // Value after this cycle, so a read right behind a write sees it
            assign coefNext[b] = wrEn[b] ? hwdata[REG_W-1:0] : coefQ[b];

            fcb_coef_reg u_coef (
                .mclk(mclk),
                .rst_n(rst_n),
                .wrEn(wrEn[b]),
                .wrData(hwdata[REG_W-1:0]),
                .regQ(coefQ[b])
            );
        end
    endgenerate

    // Bus state next values
    always_comb begin
        logic [REG_W-1:0] rv;
        rv = '0;
        wrPend_next = 1'b0;
        wrSel_next = '0;
        rdata_next = rdata_reg;
        ready_next = 1'b1;
        resp_next = HRESP_OKAY;
        if (addrPhase) begin
            rdata_next = RDATA_RST;
            if (hwrite) begin
                wrPend_next = |addrHit;
                wrSel_next = addrHit;
            end else begin
                for (int i = 0; i < NUM_BANK; i++) begin
                    if (addrHit[i]) begin
                        rv = coefNext[i];
                    end
                end
                // Bit 11 always reads back as zero
                rdata_next = BUS_W'({rv[RSVD_MSB:RSVD_LSB], 1'b0,
                                     rv[COEF_MSB-1:COEF_LSB]}); // RULE_06
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_reg <= 1'b0;
            wrSel_reg <= '0;
            rdata_reg <= RDATA_RST;
            ready_reg <= 1'b1;
            resp_reg <= HRESP_OKAY;
        end else begin
            wrPend_reg <= wrPend_next;
            wrSel_reg <= wrSel_next;
            rdata_reg <= rdata_next;
            ready_reg <= ready_next;
            resp_reg <= resp_next;
        end
    end

    assign hrdata = rdata_reg;
    assign hreadyout = ready_reg;
    assign hresp = resp_reg;

    // Coefficient fields straight from storage; reserved bits dropped
    assign tap6Coef = coefQ[0][COEF_MSB:COEF_LSB]; // RULE_02
    assign tap7Coef = coefQ[1][COEF_MSB:COEF_LSB]; // RULE_03
    assign tap8Coef = coefQ[2][COEF_MSB:COEF_LSB]; // RULE_04
    assign tap9Coef = coefQ[3][COEF_MSB:COEF_LSB]; // RULE_05

    // Sign-extend every 12-bit tap; the center tap is already full width
    always_comb begin
        filtCoefs[0] = CTR_W'(signed'(tap1Coef)); // RULE_01
        filtCoefs[1] = CTR_W'(signed'(tap2Coef));
        filtCoefs[2] = CTR_W'(signed'(tap3Coef));
        filtCoefs[3] = CTR_W'(signed'(tap4Coef));
        filtCoefs[4] = centerTapCoef[CTR_MSB:0]; // RULE_09
        for (int i = 0; i < NUM_BANK; i++) begin
            // Live register contents feed the taps directly
            filtCoefs[5+i] = CTR_W'(signed'(
                coefQ[i][COEF_MSB:COEF_LSB])); // RULE_01 RULE_08 RULE_11
        end
    end

    // Filter runs only in dual-channel mode
    fcb_fir #(
        .SAMP_W(SAMP_W),
        .ACC_W(ACC_W)
    ) u_fir (
        .mclk(mclk),
        .rst_n(rst_n),
        .enable(dualChanMode),
        .sampleValid(sampleValid),
        .sampleIn(sampleIn),
        .coefs(filtCoefs),
        .filtOut(filtOut),
        .filtValid(filtValid)
    ); // RULE_09 RULE_10

endmodule // fcb_bank

/* File: rtl/fcb_coef_reg.sv */
// One 16-bit coefficient register with write enable
module fcb_coef_reg
    import fcb_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Write side
    input wire logic wrEn,
    input wire logic [fcb_pkg::REG_W-1:0] wrData,
    // Stored value
    output logic [fcb_pkg::REG_W-1:0] regQ
);
    logic [REG_W-1:0] val_reg;
    logic [REG_W-1:0] val_next;

    // Reserved bits are stored as written
    always_comb begin
        val_next = val_reg;
        if (wrEn) begin
            val_next = wrData; // RULE_08
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            val_reg <= COEF_RST; // RULE_07
        end else begin
            val_reg <= val_next;
        end
    end

    assign regQ = val_reg;

endmodule // fcb_coef_reg

/* File: rtl/fcb_fir.sv */
// Nine-tap equaliser filter datapath for channel B
module fcb_fir
    import fcb_pkg::*;
#(
    parameter int SAMP_W = 12,
    parameter int ACC_W = 34
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Mode and samples
    input wire logic enable,
    input wire logic sampleValid,
    input wire logic [SAMP_W-1:0] sampleIn,
    // Coefficients, sign-extended to the center tap width, tap 1 first
    input wire logic [fcb_pkg::NUM_TAPS-1:0][fcb_pkg::CTR_W-1:0] coefs,
    // Result
    output logic [ACC_W-1:0] filtOut,
    output logic filtValid
);
    logic [SAMP_W-1:0] line_reg [NUM_TAPS-1];
    logic [SAMP_W-1:0] line_next [NUM_TAPS-1];
    logic [SAMP_W-1:0] window [NUM_TAPS];
    logic signed [ACC_W-1:0] prod [NUM_TAPS];
    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] acc_next;
    logic valid_reg;
    logic valid_next;

    assign window[0] = sampleIn;

    genvar k;
    generate
        for (k = 0; k < NUM_TAPS; k++) begin : g_tap
            logic signed [ACC_W-1:0] cx;
            logic signed [ACC_W-1:0] sx;
            if (k > 0) begin : g_win
                assign window[k] = line_reg[k-1];
            end
            assign cx = ACC_W'(signed'(coefs[k]));
            assign sx = ACC_W'(signed'(window[k]));
            assign prod[k] = cx * sx; // RULE_10
        end
    endgenerate

    always_comb begin
        logic signed [ACC_W-1:0] sum;
        sum = '0;
        acc_next = acc_reg;
        valid_next = 1'b0;
        for (int i = 0; i < NUM_TAPS - 1; i++) begin
            line_next[i] = line_reg[i];
        end
        if (enable && sampleValid) begin
            for (int i = 0; i < NUM_TAPS; i++) begin
                sum = sum + prod[i]; // RULE_10
            end
            acc_next = sum;
            valid_next = 1'b1;
            line_next[0] = sampleIn;
            for (int i = 1; i < NUM_TAPS - 1; i++) begin
                line_next[i] = line_reg[i-1];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= '0;
            valid_reg <= 1'b0;
            for (int i = 0; i < NUM_TAPS - 1; i++) begin
                line_reg[i] <= '0;
            end
        end else begin
            acc_reg <= acc_next;
            valid_reg <= valid_next;
            for (int i = 0; i < NUM_TAPS - 1; i++) begin
                line_reg[i] <= line_next[i];
            end
        end
    end

    assign filtOut = acc_reg;
    assign filtValid = valid_reg;

endmodule // fcb_fir

/* File: rtl/fcb_pkg.sv */
// Package: register map, field layout and sizes of the channel B tap bank
package fcb_pkg;

    // Bank geometry
    localparam int NUM_BANK = 4;
    localparam int REG_W = 16;
    localparam int COEF_W = 12;
    localparam int CTR_W = 18;
    localparam int NUM_TAPS = 9;
    localparam int BUS_W = 32;
    localparam int ADDR_W = 32;

    // Register indices; the byte address is four times the index
    localparam logic [11:0] IDX_TAP6 = 12'h453;
    localparam logic [11:0] IDX_TAP7 = 12'h455;
    localparam logic [11:0] IDX_TAP8 = 12'h457;
    localparam logic [11:0] IDX_TAP9 = 12'h459;
    localparam logic [11:0] BANK_IDX [NUM_BANK] = '{
        IDX_TAP6, IDX_TAP7, IDX_TAP8, IDX_TAP9
    };
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 12;

    // Field layout
    localparam int COEF_LSB = 0;
    localparam int COEF_MSB = 11;
    localparam int RSVD_LSB = 12;
    localparam int RSVD_MSB = 15;
    localparam int CTR_MSB = 17;

    // Reset values
    localparam logic [REG_W-1:0] COEF_RST = 16'h0000;
    localparam logic [BUS_W-1:0] RDATA_RST = 32'h0000_0000;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ = 2'b11;
    localparam logic HRESP_OKAY = 1'b0;

endpackage : fcb_pkg

/* File: verification/fcb_bank_chk.sv */
// Checker: bus and filter timing relations of the channel B tap bank
module fcb_bank_chk
    import fcb_pkg::*;
#(
    parameter int ACC_W = 34
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Bus
    input wire logic hsel,
    input wire logic [fcb_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [fcb_pkg::BUS_W-1:0] hwdata,
    input wire logic hready,
    input wire logic [fcb_pkg::BUS_W-1:0] hrdata,
    // Filter
    input wire logic dualChanMode,
    input wire logic sampleValid,
    input wire logic [fcb_pkg::COEF_W-1:0] tap6Coef,
    input wire logic [fcb_pkg::COEF_W-1:0] tap7Coef,
    input wire logic [fcb_pkg::COEF_W-1:0] tap8Coef,
    input wire logic [fcb_pkg::COEF_W-1:0] tap9Coef,
    input wire logic [ACC_W-1:0] filtOut,
    input wire logic filtValid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence sWr(a);
        hsel && hready && htrans[1] && hwrite && haddr == a;
    endsequence
    sequence sRd;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    // Field follows the data phase one edge later
    property pWr(a, q);
        sWr(a) ##1 1'b1 |=> q == $past(hwdata[11:0]);
    endproperty
    property pRdMsb;
        sRd |=> hrdata[31:16] == 16'h0 && !hrdata[11];
    endproperty
    // Reset release finds every field and the result cleared
    property pRst;
        $rose(rst_n) |-> {tap6Coef, tap7Coef, tap8Coef, tap9Coef,
            filtOut} == '0;
    endproperty
    property pTake;
        dualChanMode && sampleValid |=> filtValid;
    endproperty
    property pIdle;
        !(dualChanMode && sampleValid) |=> !filtValid && $stable(filtOut);
    endproperty
    AST_TAP6: assert property (pWr(32'h114c, tap6Coef))
        else $error("tap6 field not loaded");
    AST_TAP7: assert property (pWr(32'h1154, tap7Coef))
        else $error("tap7 field not loaded");
    AST_TAP8: assert property (pWr(32'h115c, tap8Coef))
        else $error("tap8 field not loaded");
    AST_TAP9: assert property (pWr(32'h1164, tap9Coef))
        else $error("tap9 field not loaded");
    AST_RDMSB: assert property (pRdMsb)
        else $error("read data top bits not zero");
    AST_RST: assert property (pRst)
        else $error("bank not cleared by reset");
    AST_TAKE: assert property (pTake)
        else $error("accepted sample gave no result");
    AST_IDLE: assert property (pIdle)
        else $error("result moved without a sample");
endmodule // fcb_bank_chk

/* File: verification/fcb_bank_tb.sv */
// Testbench: register access and filter checks of the channel B tap bank
module fcb_bank_tb
    import fcb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ACC_W = 34;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, dualChanMode = 1'b0, sampleValid = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, filtValid;
    logic [11:0] sampleIn = 12'h0;
    logic [11:0] tapIn [4] = '{12'h801, 12'h7ff, 12'h003, 12'hffd};
    logic [17:0] centerTapCoef = 18'h2_0003;
    logic [11:0] tapOut [4];
    logic [ACC_W-1:0] filtOut;
    int bad_count = 0, checked = 0, cycles = 0;
    longint coef [9];
    longint hist [9] = '{default: 0};
    logic [31:0] wd [4] = '{32'hffff_f9a1, 32'h1234_8a55, 32'h0000_7ffe,
        32'hdead_c801};

    fcb_bank #(.SAMP_W(12), .ACC_W(ACC_W)) i_fcb_bank (
        .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .dualChanMode(dualChanMode), .tap1Coef(tapIn[0]),
        .tap2Coef(tapIn[1]), .tap3Coef(tapIn[2]), .tap4Coef(tapIn[3]),
        .centerTapCoef(centerTapCoef), .sampleValid(sampleValid),
        .sampleIn(sampleIn), .tap6Coef(tapOut[0]), .tap7Coef(tapOut[1]),
        .tap8Coef(tapOut[2]), .tap9Coef(tapOut[3]), .filtOut(filtOut),
        .filtValid(filtValid)
    );

    always #4 mclk = ~mclk;

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: word %h not %h", $time, got, exp);
        end
    endtask

    task automatic cmp_filt(input logic [ACC_W-1:0] got,
        input logic [ACC_W-1:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: sum %h not %h", $time, got, exp);
        end
    endtask

    // Holds each phase until hready is seen high at an edge
    task automatic wait_ready();
        do @(posedge mclk); while (hreadyout !== 1'b1);
    endtask

    task automatic bus_addr(input logic [31:0] a, input logic w);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        wait_ready();
        htrans <= 2'b00;
    endtask

    task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
        bus_addr(a, 1'b1);
        hwdata <= d;
        wait_ready();
    endtask

    task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
        bus_addr(a, 1'b0);
        wait_ready();
        d = hrdata;
        cmp_word(32'(hresp), 32'(HRESP_OKAY));
    endtask

    function automatic logic [31:0] reg_addr(input int i);
        return 32'({BANK_IDX[i], 2'b00});
    endfunction

    task automatic check_zero();
        logic [31:0] rd;
        for (int i = 0; i < 4; i++) begin
            bus_read(reg_addr(i), rd);
            cmp_word(rd, 32'h0);
            cmp_word(32'(tapOut[i]), 32'h0);
        end
        cmp_filt(filtOut, '0);
    endtask

    // One sample at a time; the result is looked at mid-cycle
    task automatic push(input logic [11:0] x);
        longint acc;
        sampleValid <= 1'b1;
        sampleIn <= x;
        @(posedge mclk);
        sampleValid <= 1'b0;
        @(negedge mclk);
        acc = 0;
        cmp_word(32'(filtValid), 32'(dualChanMode));
        if (dualChanMode) begin
            for (int k = 8; k > 0; k--) hist[k] = hist[k-1];
            hist[0] = longint'(signed'(x));
            for (int k = 0; k < 9; k++) acc += coef[k] * hist[k];
            cmp_filt(filtOut, acc[ACC_W-1:0]);
        end
        @(posedge mclk);
    endtask

    initial begin
        logic [31:0] rd;
        for (int k = 0; k < 4; k++) coef[k] = longint'(signed'(tapIn[k]));
        coef[4] = longint'(signed'(centerTapCoef));
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        check_zero();
        for (int i = 0; i < 4; i++) begin
            bus_write(reg_addr(i), wd[i]);
            bus_read(reg_addr(i), rd);
            cmp_word(rd,
                {16'h0, wd[i][15:12], 1'b0, wd[i][10:0]});
            cmp_word(32'(tapOut[i]),
                32'(wd[i][11:0]));
            coef[5+i] = longint'(signed'(wd[i][11:0]));
        end
        // Misaligned and unmapped places neither store nor return data
        bus_write(32'h114d, 32'h0);
        bus_write(32'h1150, 32'hffff_ffff);
        bus_read(32'h1150, rd);
        cmp_word(rd, 32'h0);
        bus_read(reg_addr(0), rd);
        cmp_word(rd, {16'h0, wd[0][15:12], 1'b0, wd[0][10:0]});
        dualChanMode <= 1'b1;
        for (int k = 1; k < 13; k++) push(12'(k * 12'h35b));
        push(12'h800);
        push(12'h7ff);
        bus_write(reg_addr(0), 32'h0000_0c01);
        coef[5] = longint'(signed'(12'hc01));
        for (int k = 0; k < 5; k++) push(12'(k * 12'h1f3 + 1));
        dualChanMode <= 1'b0;
        push(12'h555);
        push(12'h2aa);
        dualChanMode <= 1'b1;
        for (int k = 0; k < 3; k++) push(12'(12'h9a0 - k));
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        check_zero();
        print_verdict();
    end
endmodule // fcb_bank_tb

bind fcb_bank fcb_bank_chk #(.ACC_W(ACC_W)) i_fcb_bank_chk (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .dualChanMode(dualChanMode),
    .sampleValid(sampleValid), .tap6Coef(tap6Coef), .tap7Coef(tap7Coef),
    .tap8Coef(tap8Coef), .tap9Coef(tap9Coef), .filtOut(filtOut),
    .filtValid(filtValid)
);
